// *** bench/ped_port_error_detect_checker.sv ***
// Concurrent checks on the ports of the port error detect register bank.
// Assumes it is bound into ped_port_error_detect and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module ped_port_error_detect_checker
	import ped_pkg::*;
#(
	parameter int MAX_PKT_BYTES = 276
) (
	// Clock and reset
	input wire logic                sys_clk_in,
	input wire logic                rstn_in,
	// Register bus
	input wire logic [7:0]          avs_address_in,
	input wire logic                avs_read_in,
	input wire logic                avs_write_in,
	input wire logic [3:0]          avs_byteenable_in,
	input wire ped_pkg::ped_word_t  avs_writedata_in,
	input wire logic                avs_waitrequest_out,
	// Events
	input wire logic                hdr_valid_in,
	input wire logic [1:0]          transport_type_field_in,
	input wire logic                maint_pkt_in,
	input wire logic [7:0]          hop_count_in,
	input wire logic                pkt_end_in,
	input wire logic [15:0]         pkt_bytes_in,
	input wire logic                max_retry_in,
	input wire logic                unmapped_dest_in,
	input wire logic                ttl_expired_in,
	input wire logic                lookup_parity_in,
	input wire logic                internal_switch_fabric_tea_in,
	input wire logic                multicast_tea_in,
	input wire logic                port_fatal_in,
	input wire logic                cs_crc_in,
	input wire logic                link_response_timeout_in,
	input wire ped_pkg::ped_word_t  rate_enable_in,
	// Outputs
	input wire ped_pkg::ped_word_t  error_flags_out,
	input wire logic                rate_increment_out,
	input wire logic                irq_status_clear_out,
	input wire logic                capture_latch_out,
	input wire logic                capture_valid_out
);
	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	logic [31:0] lanes;
	logic        rsvd_tt;
	logic        wr_done;
	logic        logic_ev;
	assign lanes = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}}, {8{avs_byteenable_in[1]}},
		{8{avs_byteenable_in[0]}}};
	assign rsvd_tt = hdr_valid_in && transport_type_field_in[1] && !(maint_pkt_in && hop_count_in == 8'h00);
	assign wr_done = avs_write_in && !avs_waitrequest_out && avs_address_in == 8'h00;
	assign logic_ev = rsvd_tt || max_retry_in || unmapped_dest_in || ttl_expired_in || lookup_parity_in
		|| internal_switch_fabric_tea_in || multicast_tea_in || port_fatal_in;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	AST_BUS_TAKE: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
		else $error("request not answered after one wait cycle");
	AST_BUS_ONE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
		else $error("waitrequest low for more than one cycle");
	AST_INC: assert property (rate_increment_out == $past(wr_done && ((avs_writedata_in & lanes & 32'hE000_7E01 & rate_enable_in) != 32'h0000_0000)))
		else $error("rate increment does not match write");
	AST_IRQ_CLR: assert property (irq_status_clear_out == $past(wr_done && avs_byteenable_in == 4'hF && (avs_writedata_in & 32'hE000_7E01) == 32'h0000_0000))
		else $error("interrupt clear does not match write");
	AST_LOGICAL: assert property (logic_ev |-> ##2 error_flags_out[0])
		else $error("logical error flag not set");
	AST_VALID: assert property (capture_valid_out == $past(rsvd_tt || unmapped_dest_in))
		else $error("capture valid wrong");
	AST_LATCH: assert property (capture_latch_out == $past(rsvd_tt || unmapped_dest_in || max_retry_in))
		else $error("capture latch wrong");
	AST_CS_CRC: assert property (cs_crc_in |-> ##2 error_flags_out[9])
		else $error("symbol checksum flag not set");
	AST_SIZE: assert property (pkt_end_in && pkt_bytes_in > MAX_PKT_BYTES |-> ##2 error_flags_out[14])
		else $error("oversize flag not set");
	AST_TIMEOUT: assert property (link_response_timeout_in |-> ##2 error_flags_out[31])
		else $error("timeout flag not set");
	AST_RESERVED: assert property ((error_flags_out & 32'h1FFF_81FE) == 32'h0000_0000)
		else $error("reserved flag bit set");

	cover property (wr_done);
	cover property (capture_valid_out);
	cover property (rate_increment_out);
endmodule

bind ped_port_error_detect ped_port_error_detect_checker #(.MAX_PKT_BYTES(MAX_PKT_BYTES)) u_ped_port_error_detect_checker (
	.sys_clk_in, .rstn_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_byteenable_in, .avs_writedata_in,
	.avs_waitrequest_out, .hdr_valid_in, .transport_type_field_in, .maint_pkt_in, .hop_count_in, .pkt_end_in,
	.pkt_bytes_in, .max_retry_in, .unmapped_dest_in, .ttl_expired_in, .lookup_parity_in,
	.internal_switch_fabric_tea_in, .multicast_tea_in, .port_fatal_in, .cs_crc_in, .link_response_timeout_in,
	.rate_enable_in, .error_flags_out, .rate_increment_out, .irq_status_clear_out, .capture_latch_out,
	.capture_valid_out);

`default_nettype wire

// *** bench/ped_port_error_detect_tb_top.sv ***
// Self-checking testbench of the port error detect register bank.
// Assumes the design files and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module ped_port_error_detect_tb_top;
	import ped_pkg::*;
	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [3:0]  be = 4'hF;
	ped_word_t   wdata = 32'h0000_0000;
	ped_word_t   rdata;
	logic        wreq;
	logic        hv = 1'b0;
	logic [1:0]  tt = 2'h0;
	logic        mt = 1'b0;
	logic [7:0]  hop = 8'h00;
	logic        pe = 1'b0;
	logic [15:0] pb = 16'h0000;
	logic [6:0]  lg = 7'h00;
	ped_word_t   ln = 32'h0000_0000;
	ped_word_t   ren = 32'h0000_0000;
	ped_word_t   flags;
	logic        inc, iclr, lat, val;
	int          miscompares = 0, tests_run = 0, cyc = 0, ninc = 0, nclr = 0, nlat = 0, nval = 0, eclr = 0;
	int          lbits[8] = '{9, 10, 11, 12, 13, 29, 30, 31};
	ped_word_t   q;

	ped_port_error_detect u_ped_port_error_detect (
		.sys_clk_in(clk), .rstn_in(rstn), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_byteenable_in(be), .avs_writedata_in(wdata), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
		.hdr_valid_in(hv), .transport_type_field_in(tt), .maint_pkt_in(mt), .hop_count_in(hop),
		.pkt_end_in(pe), .pkt_bytes_in(pb), .max_retry_in(lg[0]), .unmapped_dest_in(lg[1]),
		.ttl_expired_in(lg[2]), .lookup_parity_in(lg[3]), .internal_switch_fabric_tea_in(lg[4]),
		.multicast_tea_in(lg[5]), .port_fatal_in(lg[6]), .cs_crc_in(ln[9]), .ack_symbol_bad_id_in(ln[10]),
		.not_accepted_symbol_seen_in(ln[11]), .packet_bad_ack_id_in(ln[12]), .packet_checksum_fault_in(ln[13]),
		.delimiter_alignment_fault_in(ln[29]), .unexpected_ack_symbol_in(ln[30]),
		.link_response_timeout_in(ln[31]), .rate_enable_in(ren), .error_flags_out(flags),
		.rate_increment_out(inc), .irq_status_clear_out(iclr), .capture_latch_out(lat), .capture_valid_out(val));

	always #5 clk = ~clk;

	always @(posedge clk) begin
		cyc <= cyc + 1;
		ninc <= ninc + int'(inc === 1'b1);
		nclr <= nclr + int'(iclr === 1'b1);
		nlat <= nlat + int'(lat === 1'b1);
		nval <= nval + int'(val === 1'b1);
		if (cyc == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic bus(input logic w, input logic [7:0] a, input ped_word_t d, input logic [3:0] b);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		be <= b;
		do @(posedge clk); while (wreq !== 1'b0);
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	task automatic chk(input string n, input ped_word_t e, input ped_word_t g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic rchk(input string n, input ped_word_t e);
		bus(1'b0, 8'h00, 32'h0000_0000, 4'hF);
		chk(n, e, q);
		chk({n, " port"}, e, flags);
	endtask

	task automatic clr0();
		bus(1'b1, 8'h00, 32'h0000_0000, 4'hF);
		eclr++;
	endtask

	task automatic fire(input ped_word_t l, input logic [6:0] g);
		@(posedge clk);
		ln <= l;
		lg <= g;
		@(posedge clk);
		ln <= 32'h0000_0000;
		lg <= 7'h00;
		repeat (3) @(posedge clk);
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rchk("reset value", 32'h0000_0000);
		foreach (lbits[i]) begin
			fire(ped_word_t'(1) << lbits[i], 7'h00);
			rchk("link flag", ped_word_t'(1) << lbits[i]);
			clr0();
			rchk("link cleared", 32'h0000_0000);
		end
		for (int i = 0; i < 7; i++) begin
			fire(32'h0000_0000, 7'h01 << i);
			rchk("logical flag", 32'h0000_0001);
			clr0();
		end
		for (int t = 0; t < 4; t++) begin
			for (int c = 0; c < 3; c++) begin
				@(posedge clk);
				hv <= 1'b1;
				tt <= 2'(t);
				mt <= (c != 0);
				hop <= (c == 2) ? 8'h05 : 8'h00;
				@(posedge clk);
				hv <= 1'b0;
				repeat (3) @(posedge clk);
				rchk("transport type", (t >= 2 && c != 1) ? 32'h0000_0001 : 32'h0000_0000);
				clr0();
			end
		end
		chk("capture latches", 32'h0000_0006, ped_word_t'(nlat));
		chk("capture valids", 32'h0000_0005, ped_word_t'(nval));
		for (int s = 0; s < 2; s++) begin
			@(posedge clk);
			pe <= 1'b1;
			pb <= (s == 0) ? 16'h0114 : 16'h0115;
			@(posedge clk);
			pe <= 1'b0;
			repeat (3) @(posedge clk);
			rchk("oversize", (s == 0) ? 32'h0000_0000 : 32'h0000_4000);
		end
		clr0();
		fire(32'h8000_2200, 7'h04);
		bus(1'b1, 8'h00, 32'hFFFF_FFFF, 4'hF);
		rchk("write ones keeps", 32'h8000_2201);
		bus(1'b1, 8'h00, 32'h0000_0000, 4'hE);
		rchk("lane clear", 32'h0000_0001);
		bus(1'b1, 8'h04, 32'h0000_0000, 4'hF);
		rchk("unmapped write", 32'h0000_0001);
		bus(1'b0, 8'h04, 32'h0000_0000, 4'hF);
		chk("unmapped read", 32'h0000_0000, q);
		fork
			clr0();
			fire(32'h0000_2000, 7'h00);
		join
		rchk("set beats clear", 32'h0000_2000);
		clr0();
		@(posedge clk);
		ren <= 32'h0000_0200;
		bus(1'b1, 8'h00, 32'h0000_2000, 4'hF);
		bus(1'b1, 8'h00, 32'h0000_0200, 4'hF);
		bus(1'b1, 8'h00, 32'h0000_0200, 4'hE);
		bus(1'b1, 8'h00, 32'h0000_0200, 4'h1);
		rchk("writes never set", 32'h0000_0000);
		repeat (3) @(posedge clk);
		chk("rate increments", 32'h0000_0002, ped_word_t'(ninc));
		chk("irq clears", ped_word_t'(eclr), ped_word_t'(nclr));
		wrap_up();
	end
endmodule

`default_nettype wire

// *** rtl/ped_avmm_slave.sv ***
// Avalon-MM slave with waitrequest for the port error detect register bank.
// Assumes the master holds its request until it samples waitrequest low.
`timescale 1ns/1ps
`default_nettype none
`include "ped_defines.svh"

module ped_avmm_slave (
	// Clock and reset
	input  wire logic               sys_clk_in,
	input  wire logic               rstn_in,
	// Avalon-MM
	input  wire logic [7:0]         avs_address_in,
	input  wire logic               avs_read_in,
	input  wire logic               avs_write_in,
	input  wire logic [3:0]         avs_byteenable_in,
	input  wire ped_pkg::ped_word_t avs_writedata_in,
	output var  ped_pkg::ped_word_t avs_readdata_out,
	output logic                    avs_waitrequest_out,
	// Register core side
	ped_reg_if.bus                  regs
);
	import ped_pkg::*;

	ped_bus_state_t state;
	ped_bus_state_t next_state;
	ped_word_t      next_readdata;

	// ------------------------------------------------------------------------
	// Access sequencing
	// ------------------------------------------------------------------------
	// Every request waits one cycle, then completes in the acknowledge cycle.
	always_comb begin
		next_state    = state;
		next_readdata = avs_readdata_out;
		case (state)
			PED_BUS_IDLE: begin
				if (avs_read_in || avs_write_in) begin
					next_state = PED_BUS_ACK;
				end
				if (avs_read_in) begin
					next_readdata = regs.rdata;
				end
			end
			PED_BUS_ACK: begin
				next_state = PED_BUS_IDLE;
			end
			default: begin
				next_state = PED_BUS_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state            <= PED_BUS_IDLE;
			avs_readdata_out <= 32'h0000_0000;
		end else begin
			state            <= next_state;
			avs_readdata_out <= next_readdata;
		end
	end

	assign avs_waitrequest_out = (state != PED_BUS_ACK);
	assign regs.access         = (state == PED_BUS_ACK);
	assign regs.wr             = avs_write_in;
	assign regs.addr           = avs_address_in;
	assign regs.wdata          = avs_writedata_in;
	assign regs.be             = avs_byteenable_in;
endmodule

`default_nettype wire

// *** rtl/ped_defines.svh ***
// Offsets, field positions, reset values and limits of the port error detect register bank.
// Assumes inclusion by bare name from the rtl folder.
`ifndef PED_DEFINES_SVH
`define PED_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define PED_ADDR_W            8
`define PED_OFF_ERR_DETECT    8'h00
`define PED_RST_ERR_DETECT    32'h0000_0000

// ----------------------------------------------------------------------------
// Field positions of the error detect register
// ----------------------------------------------------------------------------
`define PED_BIT_LOGICAL       0
`define PED_BIT_CS_CRC        9
`define PED_BIT_ACK_BAD_ID    10
`define PED_BIT_NOT_ACC       11
`define PED_BIT_PKT_BAD_ACK   12
`define PED_BIT_PKT_CRC       13
`define PED_BIT_PKT_OVERSIZE  14
`define PED_BIT_DELIMITER     29
`define PED_BIT_UNEXP_ACK     30
`define PED_BIT_LINK_TIMEOUT  31
`define PED_IMPL_MASK         32'hE000_7E01

// ----------------------------------------------------------------------------
// Packet checks
// ----------------------------------------------------------------------------
`define PED_MAX_PKT_BYTES     276
`define PED_TT_RSVD_A         2'h2
`define PED_TT_RSVD_B         2'h3
`define PED_HOP_ZERO          8'h00

`endif

// *** rtl/ped_event_decode.sv ***
// Turns raw link and fabric error events into per-bit set requests.
// Assumes all event inputs are one-cycle pulses on the register bus clock.
`timescale 1ns/1ps
`default_nettype none
`include "ped_defines.svh"

module ped_event_decode #(
	parameter int MAX_PKT_BYTES = `PED_MAX_PKT_BYTES
) (
	// Clock and reset
	input  wire logic               sys_clk_in,
	input  wire logic               rstn_in,
	// Received packet header and end
	input  wire logic               hdr_valid_in,
	input  wire logic [1:0]         transport_type_field_in,
	input  wire logic               maint_pkt_in,
	input  wire logic [7:0]         hop_count_in,
	input  wire logic               pkt_end_in,
	input  wire logic [15:0]        pkt_bytes_in,
	// Logical and fabric events
	input  wire logic               max_retry_in,
	input  wire logic               unmapped_dest_in,
	input  wire logic               ttl_expired_in,
	input  wire logic               lookup_parity_in,
	input  wire logic               internal_switch_fabric_tea_in,
	input  wire logic               multicast_tea_in,
	input  wire logic               port_fatal_in,
	// Link events
	input  wire logic               cs_crc_in,
	input  wire logic               ack_symbol_bad_id_in,
	input  wire logic               not_accepted_symbol_seen_in,
	input  wire logic               packet_bad_ack_id_in,
	input  wire logic               packet_checksum_fault_in,
	input  wire logic               delimiter_alignment_fault_in,
	input  wire logic               unexpected_ack_symbol_in,
	input  wire logic               link_response_timeout_in,
	// Decoded results
	output var  ped_pkg::ped_word_t set_out,
	output logic                    capture_latch_out,
	output logic                    capture_valid_out
);
	import ped_pkg::*;

	if (MAX_PKT_BYTES < 1 || MAX_PKT_BYTES > 65535) begin : g_bad_max_bytes
		$error("MAX_PKT_BYTES out of range");
	end

	localparam logic [15:0] MAX_BYTES = 16'(MAX_PKT_BYTES);

	ped_word_t next_set;
	logic      next_latch;
	logic      next_valid;
	logic      rsvd_tt;

	// ------------------------------------------------------------------------
	// Event decoding
	// ------------------------------------------------------------------------
	always_comb begin
		next_set = 32'h0000_0000;
		rsvd_tt  = hdr_valid_in
			&& (transport_type_field_in == `PED_TT_RSVD_A || transport_type_field_in == `PED_TT_RSVD_B)
			&& !(maint_pkt_in && hop_count_in == `PED_HOP_ZERO);
		next_set[`PED_BIT_LOGICAL] = rsvd_tt || max_retry_in || unmapped_dest_in || ttl_expired_in
			|| lookup_parity_in || internal_switch_fabric_tea_in || multicast_tea_in
			|| port_fatal_in;
		next_set[`PED_BIT_CS_CRC]       = cs_crc_in;
		next_set[`PED_BIT_ACK_BAD_ID]   = ack_symbol_bad_id_in;
		next_set[`PED_BIT_NOT_ACC]      = not_accepted_symbol_seen_in;
		next_set[`PED_BIT_PKT_BAD_ACK]  = packet_bad_ack_id_in;
		next_set[`PED_BIT_PKT_CRC]      = packet_checksum_fault_in;
		next_set[`PED_BIT_PKT_OVERSIZE] = pkt_end_in && (pkt_bytes_in > MAX_BYTES);
		next_set[`PED_BIT_DELIMITER]    = delimiter_alignment_fault_in;
		next_set[`PED_BIT_UNEXP_ACK]    = unexpected_ack_symbol_in;
		next_set[`PED_BIT_LINK_TIMEOUT] = link_response_timeout_in;
		// Capture holds meaningful contents only for reserved type and unmapped destination.
		next_valid = rsvd_tt || unmapped_dest_in;
		// Max retry still latches, but what is latched is the last received packet.
		next_latch = next_valid || max_retry_in;
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			set_out           <= 32'h0000_0000;
			capture_latch_out <= 1'b0;
			capture_valid_out <= 1'b0;
		end else begin
			set_out           <= next_set;
			capture_latch_out <= next_latch;
			capture_valid_out <= next_valid;
		end
	end
endmodule

`default_nettype wire

// *** rtl/ped_pkg.sv ***
// Types shared by the port error detect register bank.
// Assumes nothing of its surroundings.
package ped_pkg;

	typedef logic [31:0] ped_word_t;

	typedef enum logic [0:0] {
		PED_BUS_IDLE = 1'b0,
		PED_BUS_ACK  = 1'b1
	} ped_bus_state_t;

endpackage

// *** rtl/ped_port_error_detect.sv ***
// Per-port error detect register with Avalon-MM access and error event inputs.
// Assumes event inputs and rate enables come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "ped_defines.svh"

//
// Behaviour
// - Non-zero write increments error rate counter when a written bit is rate-enabled.
// - Increment strobe feeds outside threshold logic that reports to software.
// - Bit 0 sets on any logical, transport, fabric or port fatal error.
// - Transport type 10 or 11 is reserved, except maintenance with hop count zero.
// - Clearing every bit also clears six related interrupt status flags.
// - Capture contents flagged valid only for reserved type and unmapped destination.
// - Max retry latches the last received packet, not the retried one.
// - Bit 9 sets on control symbol CRC failure.
// - Bit 10 sets on acknowledge with unexpected ackID; capture not valid.
// - Bit 11 sets on not-accepted symbol; bit 12 on packet bad ackID.
// - Bit 13 sets on received packet CRC failure.
// - Bit 14 sets when a received packet exceeds 276 bytes.
// - Bit 31 sets on acknowledge or link-response timeout; nothing captured.
// - Bit 29 on delimiter or code group fault; bit 30 on unexpected acknowledge.
module ped_port_error_detect #(
	parameter int MAX_PKT_BYTES = `PED_MAX_PKT_BYTES
) (
	// Clock and reset
	input  wire logic               sys_clk_in,
	input  wire logic               rstn_in,
	// Avalon-MM register bus
	input  wire logic [7:0]         avs_address_in,
	input  wire logic               avs_read_in,
	input  wire logic               avs_write_in,
	input  wire logic [3:0]         avs_byteenable_in,
	input  wire ped_pkg::ped_word_t avs_writedata_in,
	output var  ped_pkg::ped_word_t avs_readdata_out,
	output logic                    avs_waitrequest_out,
	// Received packet header and end
	input  wire logic               hdr_valid_in,
	input  wire logic [1:0]         transport_type_field_in,
	input  wire logic               maint_pkt_in,
	input  wire logic [7:0]         hop_count_in,
	input  wire logic               pkt_end_in,
	input  wire logic [15:0]        pkt_bytes_in,
	// Logical and fabric events
	input  wire logic               max_retry_in,
	input  wire logic               unmapped_dest_in,
	input  wire logic               ttl_expired_in,
	input  wire logic               lookup_parity_in,
	input  wire logic               internal_switch_fabric_tea_in,
	input  wire logic               multicast_tea_in,
	input  wire logic               port_fatal_in,
	// Link events
	input  wire logic               cs_crc_in,
	input  wire logic               ack_symbol_bad_id_in,
	input  wire logic               not_accepted_symbol_seen_in,
	input  wire logic               packet_bad_ack_id_in,
	input  wire logic               packet_checksum_fault_in,
	input  wire logic               delimiter_alignment_fault_in,
	input  wire logic               unexpected_ack_symbol_in,
	input  wire logic               link_response_timeout_in,
	// Rate enable register contents
	input  wire ped_pkg::ped_word_t rate_enable_in,
	// Join outputs
	output var  ped_pkg::ped_word_t error_flags_out,
	output logic                    rate_increment_out,
	output logic                    irq_status_clear_out,
	output logic                    capture_latch_out,
	output logic                    capture_valid_out
);
	import ped_pkg::*;

	// ------------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------------
	// Expands byte enables into a bit mask.
	function automatic ped_word_t lane_mask(input logic [3:0] be);
		ped_word_t m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return m;
	endfunction

	// ------------------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------------------
	ped_reg_if regs ();

	ped_word_t hw_set;

	ped_avmm_slave u_slave (
		.sys_clk_in          (sys_clk_in),
		.rstn_in             (rstn_in),
		.avs_address_in      (avs_address_in),
		.avs_read_in         (avs_read_in),
		.avs_write_in        (avs_write_in),
		.avs_byteenable_in   (avs_byteenable_in),
		.avs_writedata_in    (avs_writedata_in),
		.avs_readdata_out    (avs_readdata_out),
		.avs_waitrequest_out (avs_waitrequest_out),
		.regs                (regs.bus)
	);

	ped_event_decode #(
		.MAX_PKT_BYTES (MAX_PKT_BYTES)
	) u_decode (
		.sys_clk_in                    (sys_clk_in),
		.rstn_in                       (rstn_in),
		.hdr_valid_in                  (hdr_valid_in),
		.transport_type_field_in       (transport_type_field_in),
		.maint_pkt_in                  (maint_pkt_in),
		.hop_count_in                  (hop_count_in),
		.pkt_end_in                    (pkt_end_in),
		.pkt_bytes_in                  (pkt_bytes_in),
		.max_retry_in                  (max_retry_in),
		.unmapped_dest_in              (unmapped_dest_in),
		.ttl_expired_in                (ttl_expired_in),
		.lookup_parity_in              (lookup_parity_in),
		.internal_switch_fabric_tea_in (internal_switch_fabric_tea_in),
		.multicast_tea_in              (multicast_tea_in),
		.port_fatal_in                 (port_fatal_in),
		.cs_crc_in                     (cs_crc_in),
		.ack_symbol_bad_id_in          (ack_symbol_bad_id_in),
		.not_accepted_symbol_seen_in   (not_accepted_symbol_seen_in),
		.packet_bad_ack_id_in          (packet_bad_ack_id_in),
		.packet_checksum_fault_in      (packet_checksum_fault_in),
		.delimiter_alignment_fault_in  (delimiter_alignment_fault_in),
		.unexpected_ack_symbol_in      (unexpected_ack_symbol_in),
		.link_response_timeout_in      (link_response_timeout_in),
		.set_out                       (hw_set),
		.capture_latch_out             (capture_latch_out),
		.capture_valid_out             (capture_valid_out)
	);

	// ------------------------------------------------------------------------
	// Register core
	// ------------------------------------------------------------------------
	ped_word_t flags;
	ped_word_t next_flags;
	logic      next_increment;
	logic      next_irq_clear;
	logic      det_write;
	ped_word_t lanes;
	ped_word_t wr_bits;

	assign det_write  = regs.access && regs.wr && (regs.addr == `PED_OFF_ERR_DETECT);
	assign lanes      = lane_mask(regs.be);
	assign wr_bits    = regs.wdata & lanes & `PED_IMPL_MASK;
	assign regs.rdata = (regs.addr == `PED_OFF_ERR_DETECT) ? flags : 32'h0000_0000;

	always_comb begin
		next_flags = flags;
		if (det_write) begin
			// Zero in an enabled lane clears that flag; ones leave it untouched.
			next_flags = flags & (regs.wdata | ~lanes);
		end
		// A hardware event in the clearing cycle wins over the clear.
		next_flags = (next_flags | hw_set) & `PED_IMPL_MASK;
		// Only a write that names an enabled error class counts toward the rate.
		next_increment = det_write && ((wr_bits & rate_enable_in) != 32'h0000_0000);
		next_irq_clear = det_write && (regs.be == 4'hF) && (wr_bits == 32'h0000_0000);
	end

	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			flags                <= `PED_RST_ERR_DETECT;
			rate_increment_out   <= 1'b0;
			irq_status_clear_out <= 1'b0;
		end else begin
			flags                <= next_flags;
			rate_increment_out   <= next_increment;
			irq_status_clear_out <= next_irq_clear;
		end
	end

	assign error_flags_out = flags;
endmodule

`default_nettype wire

// *** rtl/ped_reg_if.sv ***
// Register access carrier between the bus slave and the register core.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface ped_reg_if;
	import ped_pkg::*;

	logic             access;
	logic             wr;
	logic [7:0]       addr;
	ped_word_t        wdata;
	logic [3:0]       be;
	ped_word_t        rdata;

	modport bus (output access, output wr, output addr, output wdata, output be, input rdata);
	modport core (input access, input wr, input addr, input wdata, input be, output rdata);
endinterface

`default_nettype wire
